// *** logic/wr_burst_pkg.sv ***
// Shared constants, types and helpers of the write burst link
package wr_burst_pkg;
  // ---------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------
  localparam int COL_W     = 10;
  localparam int BG_W      = 2;
  localparam int DQ_W      = 8;
  localparam int LAT_W     = 5;
  localparam int WL_W      = 6;
  localparam int LAT_DEPTH = 32;

  // ---------------------------------------------------------------
  // Burst modes and lengths
  // ---------------------------------------------------------------
  localparam logic [1:0] BURST_FIXED_BL8 = 2'h0;
  localparam logic [1:0] BURST_OTF       = 2'h1;
  localparam logic [1:0] BURST_FIXED_BC4 = 2'h2;
  localparam logic [3:0] BEATS_BL8       = 4'h8;
  localparam logic [3:0] BEATS_BC4       = 4'h4;

  // ---------------------------------------------------------------
  // Timing counts (link clocks, ref clocks for the divider)
  // ---------------------------------------------------------------
  localparam logic [LAT_W-1:0] CWL_LOWEST     = 5'h09;
  localparam logic [7:0]       CCD_FORBIDDEN  = 8'h05;
  localparam logic [7:0]       WR_RECOVERY_CK = 8'h0c;
  localparam logic [3:0]       CK_HALF        = 4'h6;
  localparam logic [3:0]       CK_QUARTER     = 4'h3;

  // ---------------------------------------------------------------
  // Controller register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CFG      = 8'h00;
  localparam logic [7:0]  ADDR_CMD      = 8'h04;
  localparam logic [7:0]  ADDR_DATA_LO  = 8'h08;
  localparam logic [7:0]  ADDR_DATA_HI  = 8'h0c;
  localparam logic [7:0]  ADDR_KEEP     = 8'h10;
  localparam logic [7:0]  ADDR_STATUS   = 8'h14;
  localparam int          CFG_W         = 16;
  localparam int          CFG_BURST_LSB = 0;
  localparam int          CFG_PRE2_BIT  = 2;
  localparam int          CFG_AL_LSB    = 3;
  localparam int          CFG_CWL_LSB   = 8;
  localparam int          CFG_FUNC_LSB  = 13;
  localparam int          CFG_MASK_BIT  = 15;
  localparam logic [15:0] CFG_RESET     = 16'h0900;
  localparam int          CMD_W         = 14;
  localparam int          CMD_COL_LSB   = 0;
  localparam int          CMD_BG_LSB    = 10;
  localparam int          CMD_AP_BIT    = 12;
  localparam int          CMD_A12_BIT   = 13;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_CFGERR_BIT = 1;
  localparam int          ST_COUNT_LSB  = 8;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PIN_MASK    = 2'h0,
    PIN_INVERT  = 2'h1,
    PIN_TSTROBE = 2'h2
  } pin_func_t;

  typedef enum logic [1:0] {
    CRC_OFF        = 2'h0,
    CRC_NONPERSIST = 2'h1,
    CRC_PERSIST    = 2'h2
  } crc_mode_t;

  typedef struct packed {
    logic            ck;
    logic            cmd_wr;
    logic            a10;
    logic            a12;
    logic [BG_W-1:0] bg;
    logic [COL_W-1:0] col;
    logic            dqs;
    logic [DQ_W-1:0] dq;
    logic            dm_n;
  } link_t;

  typedef struct packed {
    logic             v;
    logic             bl8;
    logic             ap;
    logic [BG_W-1:0]  bg;
    logic [COL_W-1:0] col;
  } slot_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic burst_is_bl8(input logic [1:0] mode, input logic a12);
    logic r;
    r = 1'b1;
    case (mode)
      BURST_FIXED_BL8: r = 1'b1;
      BURST_OTF:       r = a12;
      BURST_FIXED_BC4: r = 1'b0;
      default:         r = 1'b1;
    endcase
    return r;
  endfunction : burst_is_bl8

  function automatic logic [WL_W-1:0] write_latency(input logic [LAT_W-1:0] al,
                                                    input logic [LAT_W-1:0] write_cas_latency);
    return {1'b0, al} + {1'b0, write_cas_latency};
  endfunction : write_latency
endpackage : wr_burst_pkg

// *** logic/wr_link_if.sv ***
// Write burst link between memory controller and memory device
`timescale 1ns/1ps
interface wr_link_if;
  import wr_burst_pkg::*;
  logic             ck;
  logic             cmd_wr;
  logic             a10;
  logic             a12;
  logic [BG_W-1:0]  bg;
  logic [COL_W-1:0] col;
  logic             dqs;
  logic [DQ_W-1:0]  dq;
  logic             dm_n;

  modport ctrl (output ck, output cmd_wr, output a10, output a12, output bg,
                output col, output dqs, output dq, output dm_n);
  modport dram (input ck, input cmd_wr, input a10, input a12, input bg,
                input col, input dqs, input dq, input dm_n);
endinterface : wr_link_if

// *** logic/wr_burst_dram.sv ***
// Memory device end: write command scheduling and burst capture
`timescale 1ns/1ps
module wr_burst_dram
  import wr_burst_pkg::*;
#(
  parameter int ORG_WIDTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  wr_link_if.dram               link,
  input  wire logic [1:0]       i_burst_mode,
  input  wire logic [LAT_W-1:0] i_additive_latency,
  input  wire logic [LAT_W-1:0] i_write_cas_latency,
  input  wire pin_func_t        i_pin_func,
  input  wire logic             i_mask_en,
  input  wire logic             i_crc_en,
  output logic                  o_wr_valid,
  output logic [BG_W-1:0]       o_wr_bank_group,
  output logic [COL_W-1:0]      o_wr_column,
  output logic [DQ_W-1:0]       o_wr_data,
  output logic                  o_wr_keep,
  output logic                  o_precharge,
  output logic [BG_W-1:0]       o_precharge_bank_group,
  output logic [(1<<BG_W)-1:0]  o_bank_open,
  output logic                  o_burst_end,
  output crc_mode_t             o_crc_mode,
  output logic                  o_data_err
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam int IDX_W = $clog2(LAT_DEPTH);

  typedef struct packed {
    link_t                     sy1;
    link_t                     sy2;
    link_t                     sy3;
    slot_t [LAT_DEPTH-1:0]     slot;
    slot_t                     cur;
    logic [3:0]                left;
    logic [2:0]                beat;
    logic                      ending;
    logic                      wr_valid;
    logic [BG_W-1:0]           wr_bg;
    logic [COL_W-1:0]          wr_col;
    logic [DQ_W-1:0]           wr_data;
    logic                      wr_keep;
    logic                      pre;
    logic [BG_W-1:0]           pre_bg;
    logic [(1<<BG_W)-1:0]      bank_open;
    logic                      burst_end;
    crc_mode_t                 crc;
    logic                      err;
  } dram_t;

  dram_t             q;
  dram_t             d;
  link_t             raw;
  slot_t             new_slot;
  logic              ck_rise;
  logic              strobe_edge;
  logic              mask_on;
  logic              inv_on;
  logic [WL_W-1:0]   wl;
  logic [WL_W-1:0]   wl_m1;
  logic [IDX_W-1:0]  ins_idx;

  // ---------------------------------------------------------------
  // Pin gathering and decode
  // ---------------------------------------------------------------
  assign raw.ck     = link.ck;
  assign raw.cmd_wr = link.cmd_wr;
  assign raw.a10    = link.a10;
  assign raw.a12    = link.a12;
  assign raw.bg     = link.bg;
  assign raw.col    = link.col;
  assign raw.dqs    = link.dqs;
  assign raw.dq     = link.dq;
  assign raw.dm_n   = link.dm_n;

  // Edges are found on the second and third stage only
  assign ck_rise     = q.sy2.ck & ~q.sy3.ck;
  assign strobe_edge = q.sy2.dqs ^ q.sy3.dqs;

  // The shared pin carries one function at a time
  assign mask_on = (ORG_WIDTH != 4) && i_mask_en && (i_pin_func == PIN_MASK);
  assign inv_on  = (i_pin_func == PIN_INVERT);

  assign wl      = write_latency(i_additive_latency, i_write_cas_latency);
  assign wl_m1   = wl - 6'h01;
  // Latency beyond the delay line is clamped; such a setting is unsupported
  assign ins_idx = (wl_m1 >= WL_W'(LAT_DEPTH)) ? IDX_W'(LAT_DEPTH - 1) : wl_m1[IDX_W-1:0];

  assign new_slot.v   = 1'b1;
  assign new_slot.bl8 = burst_is_bl8(i_burst_mode, q.sy2.a12);
  assign new_slot.ap  = q.sy2.a10;
  assign new_slot.bg  = q.sy2.bg;
  assign new_slot.col = q.sy2.col;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.sy1       = raw;
    d.sy2       = q.sy1;
    d.sy3       = q.sy2;
    d.wr_valid  = 1'b0;
    d.pre       = 1'b0;
    d.burst_end = 1'b0;

    if (!i_crc_en) begin
      d.crc = CRC_OFF;
    end else if (mask_on) begin
      d.crc = CRC_PERSIST;
    end else begin
      d.crc = CRC_NONPERSIST;
    end

    // Beat capture on either strobe edge
    if (strobe_edge) begin
      if (q.left != 4'h0) begin
        d.wr_valid = 1'b1;
        d.wr_bg    = q.cur.bg;
        d.wr_col   = {q.cur.col[COL_W-1:3], 3'(q.cur.col[2:0] + q.beat)};
        if (inv_on && !q.sy2.dm_n) begin
          d.wr_data = ~q.sy2.dq;
        end else begin
          d.wr_data = q.sy2.dq;
        end
        d.wr_keep = mask_on ? q.sy2.dm_n : 1'b1;
        d.beat    = q.beat + 3'h1;
        d.left    = q.left - 4'h1;
        if (q.left == 4'h1) begin
          d.ending = 1'b1;
        end
      end else begin
        // Strobe edge with no burst due: early data or wrong latency
        d.err = 1'b1;
      end
    end

    if (ck_rise) begin
      // First rise after the last beat closes the burst
      if (q.ending) begin
        d.burst_end = 1'b1;
        d.ending    = 1'b0;
        if (q.cur.ap) begin
          d.pre                  = 1'b1;
          d.pre_bg               = q.cur.bg;
          d.bank_open[q.cur.bg]  = 1'b0;
        end
      end

      // Burst due at this rise; may follow the previous one gaplessly
      if (q.slot[0].v) begin
        if (q.left != 4'h0) begin
          d.err = 1'b1;
        end
        d.cur                    = q.slot[0];
        d.left                   = q.slot[0].bl8 ? BEATS_BL8 : BEATS_BC4;
        d.beat                   = 3'h0;
        d.bank_open[q.slot[0].bg] = 1'b1;
      end

      for (int i = 0; i < LAT_DEPTH - 1; i++) begin
        d.slot[i] = q.slot[i+1];
      end
      d.slot[LAT_DEPTH-1] = '0;

      // Command lands write latency rises ahead
      if (q.sy2.cmd_wr) begin
        d.slot[ins_idx] = new_slot;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_wr_valid             = q.wr_valid;
  assign o_wr_bank_group        = q.wr_bg;
  assign o_wr_column            = q.wr_col;
  assign o_wr_data              = q.wr_data;
  assign o_wr_keep              = q.wr_keep;
  assign o_precharge            = q.pre;
  assign o_precharge_bank_group = q.pre_bg;
  assign o_bank_open            = q.bank_open;
  assign o_burst_end            = q.burst_end;
  assign o_crc_mode             = q.crc;
  assign o_data_err             = q.err;
endmodule : wr_burst_dram

// *** logic/wr_burst_ctrl.sv ***
// Controller end: APB registers, link clock divider, write bursts
`timescale 1ns/1ps
module wr_burst_ctrl
  import wr_burst_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  wr_link_if.ctrl          link
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD  = 3'h1,
    ST_WAIT = 3'h3,
    ST_DATA = 3'h2,
    ST_REC  = 3'h6
  } ctl_state_t;

  typedef struct packed {
    logic [3:0]       ph;
    ctl_state_t       st;
    logic [CFG_W-1:0] cfg;
    logic [CMD_W-1:0] cmd;
    logic [63:0]      data;
    logic [7:0]       keep;
    logic             go;
    logic             bl8;
    logic [7:0]       cnt;
    logic [3:0]       edges;
    logic [7:0]       sp;
    logic [7:0]       done;
    logic [31:0]      prdata;
    link_t            l;
  } ctl_t;

  localparam logic [3:0] PH_LAST   = CK_HALF + CK_HALF - 4'h1;
  // Divider starts on its last phase so the first high half is full; mask pin idles high
  localparam ctl_t       CTL_RESET = '{ph: PH_LAST, st: ST_IDLE, cfg: CFG_RESET,
                                       l: '{dm_n: 1'b1, default: '0}, default: '0};

  ctl_t             q;
  ctl_t             d;
  logic             rise;
  logic             fall;
  logic             strobe;
  logic             pre2;
  logic             mask_on;
  logic             cfg_err;
  logic             busy;
  logic             mapped;
  logic             refuse;
  logic [LAT_W-1:0] al;
  logic [LAT_W-1:0] write_cas_latency;
  logic [3:0]       len;
  logic [31:0]      st_word;

  function automatic logic [DQ_W-1:0] beat_byte(input logic [63:0] data,
                                                input logic [2:0]  idx);
    return data[{idx, 3'h0} +: DQ_W];
  endfunction : beat_byte

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign rise    = (q.ph == 4'h0) && q.l.ck;
  assign fall    = (q.ph == CK_HALF);
  assign strobe  = (q.ph == CK_QUARTER) || (q.ph == CK_HALF + CK_QUARTER);
  assign pre2    = q.cfg[CFG_PRE2_BIT];
  assign al      = q.cfg[CFG_AL_LSB +: LAT_W];
  assign write_cas_latency     = q.cfg[CFG_CWL_LSB +: LAT_W];
  // Mask only with the pin in mask function, never with inversion
  assign mask_on = q.cfg[CFG_MASK_BIT] && (q.cfg[CFG_FUNC_LSB +: 2] == PIN_MASK);
  assign cfg_err = pre2 && (write_cas_latency <= CWL_LOWEST);
  assign busy    = q.go || (q.st != ST_IDLE);
  assign len     = q.bl8 ? BEATS_BL8 : BEATS_BC4;
  assign mapped  = i_paddr inside {ADDR_CFG, ADDR_CMD, ADDR_DATA_LO, ADDR_DATA_HI,
                                   ADDR_KEEP, ADDR_STATUS};
  // Only one write in flight; a new order while busy is refused
  assign refuse  = i_pwrite && ((i_paddr == ADDR_STATUS) ||
                   ((i_paddr == ADDR_CMD) && (busy || cfg_err)));

  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && (!mapped || refuse);

  always_comb begin
    st_word                       = '0;
    st_word[ST_BUSY_BIT]          = busy;
    st_word[ST_CFGERR_BIT]        = cfg_err;
    st_word[ST_COUNT_LSB +: 8]    = q.done;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    d.ph   = (q.ph == PH_LAST) ? 4'h0 : q.ph + 4'h1;
    d.l.ck = (d.ph < CK_HALF);

    // Read data latched in setup so the access phase needs no wait
    if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        ADDR_CFG:     d.prdata = {16'h0000, q.cfg};
        ADDR_CMD:     d.prdata = {18'h00000, q.cmd};
        ADDR_DATA_LO: d.prdata = q.data[31:0];
        ADDR_DATA_HI: d.prdata = q.data[63:32];
        ADDR_KEEP:    d.prdata = {24'h000000, q.keep};
        ADDR_STATUS:  d.prdata = st_word;
        default:      d.prdata = '0;
      endcase
    end

    if (i_psel && i_penable && i_pwrite && !o_pslverr) begin
      case (i_paddr)
        ADDR_CFG:     d.cfg = i_pwdata[CFG_W-1:0];
        ADDR_CMD: begin
          d.cmd = i_pwdata[CMD_W-1:0];
          d.go  = 1'b1;
        end
        ADDR_DATA_LO: d.data[31:0] = i_pwdata;
        ADDR_DATA_HI: d.data[63:32] = i_pwdata;
        ADDR_KEEP:    d.keep = i_pwdata[7:0];
        default:      d.go = q.go;
      endcase
    end

    if (rise && (q.sp != 8'hff)) begin
      d.sp = q.sp + 8'h01;
    end

    case (q.st)
      ST_IDLE: begin
        // Spacing of five rises is skipped to six with the long preamble
        if (q.go && fall && !(pre2 && (q.sp + 8'h01 == CCD_FORBIDDEN))) begin
          d.go       = 1'b0;
          d.st       = ST_CMD;
          d.l.cmd_wr = 1'b1;
          d.l.a10    = q.cmd[CMD_AP_BIT];
          d.l.a12    = q.cmd[CMD_A12_BIT];
          d.l.bg     = q.cmd[CMD_BG_LSB +: BG_W];
          d.l.col    = q.cmd[CMD_COL_LSB +: COL_W];
          d.bl8      = burst_is_bl8(q.cfg[CFG_BURST_LSB +: 2], q.cmd[CMD_A12_BIT]);
        end
      end
      ST_CMD: begin
        if (rise) begin
          d.sp = 8'h00;
        end
        if (fall) begin
          d.l.cmd_wr = 1'b0;
          d.cnt      = {2'h0, write_latency(al, write_cas_latency)};
          d.st       = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (rise) begin
          if (q.cnt <= 8'h01) begin
            d.st     = ST_DATA;
            d.edges  = 4'h0;
            d.l.dq   = beat_byte(q.data, 3'h0);
            d.l.dm_n = mask_on ? q.keep[0] : 1'b1;
          end else begin
            d.cnt = q.cnt - 8'h01;
          end
        end
      end
      ST_DATA: begin
        if (strobe) begin
          d.l.dqs = ~q.l.dqs;
          d.edges = q.edges + 4'h1;
        end else if (rise || fall) begin
          if (q.edges == len) begin
            // Recovery counted from this first rise after the last beat
            d.st     = ST_REC;
            d.cnt    = WR_RECOVERY_CK;
            d.done   = q.done + 8'h01;
            d.l.dq   = '0;
            d.l.dm_n = 1'b1;
          end else begin
            d.l.dq   = beat_byte(q.data, q.edges[2:0]);
            d.l.dm_n = mask_on ? q.keep[q.edges[2:0]] : 1'b1;
          end
        end
      end
      ST_REC: begin
        if (rise) begin
          if (q.cnt <= 8'h01) begin
            d.st = ST_IDLE;
          end else begin
            d.cnt = q.cnt - 8'h01;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_prdata    = q.prdata;
  assign link.ck     = q.l.ck;
  assign link.cmd_wr = q.l.cmd_wr;
  assign link.a10    = q.l.a10;
  assign link.a12    = q.l.a12;
  assign link.bg     = q.l.bg;
  assign link.col    = q.l.col;
  assign link.dqs    = q.l.dqs;
  assign link.dq     = q.l.dq;
  assign link.dm_n   = q.l.dm_n;
endmodule : wr_burst_ctrl

// *** verification/wr_link_props.sv ***
// Protocol checker for the write burst link between the two ends
`timescale 1ns/1ps
module wr_link_props
  import wr_burst_pkg::*;
(
  input wire logic             i_ref_clk,
  input wire logic             i_reset_n,
  input wire logic             ck,
  input wire logic             cmd_wr,
  input wire logic             a10,
  input wire logic             a12,
  input wire logic [BG_W-1:0]  bg,
  input wire logic [COL_W-1:0] col,
  input wire logic             dqs,
  input wire logic [DQ_W-1:0]  dq,
  input wire logic             dm_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // ---------------------------------------------------------------
  // Strobe edges of the last burst, cleared by each command
  // ---------------------------------------------------------------
  logic [3:0] edges_q;
  logic       dqs_q;
  logic       cmd_q;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      edges_q <= 4'h0;
      dqs_q   <= 1'b0;
      cmd_q   <= 1'b0;
    end else begin
      dqs_q <= dqs;
      cmd_q <= cmd_wr;
      if (cmd_wr && !cmd_q) begin
        edges_q <= 4'h0;
      end else if (dqs != dqs_q) begin
        edges_q <= edges_q + 4'h1;
      end
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_CK_HIGH: assert property ($rose(ck) |-> ck[*6] ##1 !ck)
    else $error("link clock high time wrong");
  AST_CK_LOW: assert property ($fell(ck) |-> (!ck)[*6] ##1 ck)
    else $error("link clock low time wrong");
  AST_CMD_PHASE: assert property ($rose(cmd_wr) |-> (!ck)[*5] ##1 ck)
    else $error("command not centred on a clock rise");
  AST_CMD_HOLD: assert property ($rose(cmd_wr) |=>
    $stable({cmd_wr, a10, a12, bg, col})[*8] ##4 $fell(cmd_wr))
    else $error("command fields not held one link period");
  AST_IDLE_AT_CMD: assert property ($rose(cmd_wr) |-> dm_n && !dqs && dq == '0)
    else $error("data lines not idle at command");
  AST_BEAT_COUNT: assert property ($rose(cmd_wr) |-> edges_q inside {4'h0, 4'h4, 4'h8})
    else $error("burst had a wrong number of strobe edges");
  AST_DQ_CENTRED: assert property ($changed(dqs) |-> $stable(dq) ##1 $stable(dq)[*2])
    else $error("data moved near a strobe edge");
  AST_DQS_PHASE: assert property ($changed(dqs) |-> $past(ck, 4) != $past(ck, 5))
    else $error("strobe edge not four clocks after link edge");
  AST_DQS_SPACING: assert property ($changed(dqs) |=> $stable(dqs)[*5])
    else $error("strobe edges closer than a half period");
  cover property ($rose(cmd_wr) && a10);
  cover property ($rose(cmd_wr) && !a12);
  cover property ($rose(cmd_wr) && edges_q == 4'h4);
endmodule : wr_link_props

// *** verification/testbench.sv ***
// Bench: APB-driven writes carried across the link to the memory end
`timescale 1ns/1ps
module testbench;
  import wr_burst_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  mode;
  logic [4:0]  al;
  logic        mask;
  logic        wv;
  logic [9:0]  wcol;
  logic [7:0]  wdat;
  logic        wkeep;
  logic        pre;
  logic [3:0]  bopen;
  crc_mode_t   crc;
  logic        derr;
  logic        crc_en;
  logic        bend;
  logic [1:0]  wbg;
  logic [1:0]  pbg;
  logic [7:0]  dat [8];
  logic        kp [8];
  logic [9:0]  cl [8];
  logic        ckp;
  logic        dqsp;
  logic        first;
  int          nb, npre, nend, cyc, t0, lat, failures, num_checks;
  wr_link_if link_bus ();
  wr_burst_ctrl u_wr_burst_ctrl (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link_bus.ctrl));
  wr_burst_dram u_wr_burst_dram (.i_ref_clk(clk), .i_reset_n(rst_n), .link(link_bus.dram),
    .i_burst_mode(mode), .i_additive_latency(al), .i_write_cas_latency(5'h09),
    .i_pin_func(PIN_MASK), .i_mask_en(mask), .i_crc_en(crc_en), .o_wr_valid(wv),
    .o_wr_bank_group(wbg), .o_wr_column(wcol), .o_wr_data(wdat), .o_wr_keep(wkeep),
    .o_precharge(pre), .o_precharge_bank_group(pbg), .o_bank_open(bopen),
    .o_burst_end(bend), .o_crc_mode(crc), .o_data_err(derr));
  wr_link_props u_props (.i_ref_clk(clk), .i_reset_n(rst_n), .ck(link_bus.ck),
    .cmd_wr(link_bus.cmd_wr), .a10(link_bus.a10), .a12(link_bus.a12), .bg(link_bus.bg),
    .col(link_bus.col), .dqs(link_bus.dqs), .dq(link_bus.dq), .dm_n(link_bus.dm_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Monitor on the falling edge, where outputs have settled
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    cyc = cyc + 1;
    if (wv === 1'b1) begin
      dat[nb[2:0]] = wdat;
      kp[nb[2:0]] = wkeep;
      cl[nb[2:0]] = wcol;
      nb = nb + 1;
    end
    if (pre === 1'b1) npre = npre + 1;
    if (bend === 1'b1) nend = nend + 1;
    if (link_bus.ck && !ckp && link_bus.cmd_wr) begin
      t0 = cyc;
      first = 1'b1;
    end
    if (link_bus.dqs && !dqsp && first) begin
      lat = cyc - t0;
      first = 1'b0;
    end
    ckp = link_bus.ck;
    dqsp = link_bus.dqs;
    if (cyc == 20000) begin
      failures++;
      end_of_test;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err,
           output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task burst(input logic [1:0] m, input logic [4:0] a, input logic mk, input logic ap,
             input logic a12, input logic [1:0] g, input int nbe);
    logic [31:0] r;
    logic [63:0] d;
    logic [7:0]  k;
    int          np, ne;
    d = 64'h8877_6655_4433_2211;
    k = 8'h5b;
    mode <= m;
    al <= a;
    mask <= mk;
    apb(1'b1, ADDR_CFG, {16'h0, mk, 2'h0, 5'h09, a, 1'b0, m}, 1'b0, r);
    apb(1'b1, ADDR_DATA_LO, d[31:0], 1'b0, r);
    apb(1'b1, ADDR_DATA_HI, d[63:32], 1'b0, r);
    apb(1'b1, ADDR_KEEP, {24'h0, k}, 1'b0, r);
    np = npre;
    ne = nend;
    nb = 0;
    apb(1'b1, ADDR_CMD, {18'h0, a12, ap, g, 10'h0c5}, 1'b0, r);
    do apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, r); while (r[0] !== 1'b0);
    chk("beats", 32'(nbe), 32'(nb));
    for (int i = 0; i < nbe; i++) begin
      chk("keep", {31'h0, mk ? k[i] : 1'b1}, {31'h0, kp[i]});
      if (!mk || k[i]) chk("data", {24'h0, d[8*i+:8]}, {24'h0, dat[i]});
      chk("column", {22'h0, 7'h18, 3'(5 + i)}, {22'h0, cl[i]});
    end
    chk("latency", 32'((32'(a) + 9) * 12 + 4), 32'(lat));
    chk("precharge", 32'(np + 32'(ap)), 32'(npre));
    chk("burst_end", 32'(ne + 1), 32'(nend));
    chk("wr_bank_group", {30'h0, g}, {30'h0, wbg});
    if (ap) chk("pre_bank_group", {30'h0, g}, {30'h0, pbg});
    chk("bank_open", {31'h0, !ap}, {31'h0, bopen[g]});
    chk("crc", {30'h0, mk ? CRC_PERSIST : CRC_NONPERSIST}, {30'h0, crc});
  endtask : burst
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task s_refusals;
    logic [31:0] r;
    apb(1'b0, ADDR_CFG, 32'h0, 1'b0, r);
    chk("cfg_reset", 32'h0000_0900, r);
    chk("crc_off", {30'h0, CRC_OFF}, {30'h0, crc});
    crc_en <= 1'b1;
    apb(1'b1, ADDR_STATUS, 32'h0, 1'b1, r);
    apb(1'b0, 8'h18, 32'h0, 1'b1, r);
    chk("unmapped", 32'h0, r);
    apb(1'b1, ADDR_CFG, 32'h0000_0904, 1'b0, r);
    apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, r);
    chk("cfg_err", 32'h1, {31'h0, r[1]});
    apb(1'b1, ADDR_CMD, 32'h0, 1'b1, r);
    apb(1'b1, ADDR_CFG, 32'h0000_0a04, 1'b0, r);
    apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, r);
    chk("cfg_ok", 32'h0, {31'h0, r[1]});
  endtask : s_refusals
  task s_bursts;
    burst(BURST_FIXED_BL8, 5'h00, 1'b1, 1'b0, 1'b0, 2'h1, 8);
    burst(BURST_OTF, 5'h0a, 1'b0, 1'b0, 1'b1, 2'h2, 8);
    burst(BURST_OTF, 5'h00, 1'b1, 1'b1, 1'b0, 2'h3, 4);
    burst(BURST_FIXED_BC4, 5'h00, 1'b0, 1'b1, 1'b1, 2'h0, 4);
  endtask : s_bursts
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    {psel, penable, pwrite, mask, rst_n, ckp, dqsp, first, crc_en} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode = BURST_FIXED_BL8;
    al = 5'h00;
    {nb, npre, nend, cyc, t0, lat, failures, num_checks} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    s_refusals;
    s_bursts;
    chk("data_err", 32'h0, {31'h0, derr});
    end_of_test;
  end
endmodule : testbench
